// ---- hdl/ppr_port_pad_routing.sv ----
// Summary of operation
// (R1) Open-drain bit set: pin only sinks; clear: push-pull drive.
// (R2) Slew bit set limits pad slew rate; clear gives full rate.
// (R3) Each pin selects Schmitt CMOS or TTL input threshold.
// (R4) Selected threshold feeds both port reads and change detection.
// (R5) Software changes thresholds only with peripherals disabled, else spurious edge.
// (R6) Pins drive output latch data unless a peripheral output is routed.
// (R7) Any input-capable pin may carry any digital peripheral output.
// (R8) Each peripheral input has a default pin, movable by its selection register.
// (R9) Bidirectional functions need output pin selection equal to input selection.
// (R10) Analog-selected pins read 0 digitally; digital output still works.
// (R11) Weak pull-up is off whenever the pin is an output.
// (R12) Pad inputs pass two flip-flops before reads or change detection.
//
// Design decisions made here: register access over Wishbone and the register offsets.
`default_nettype none
module ppr_port_pad_routing
  import ppr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire ppr_pkg::ppr_pad_in_type pad_i,
  output ppr_pkg::ppr_pad_ctl_type pad_o,
  input wire logic [NPERIPH_OUT-1:0] periph_out_i,
  input wire logic [NPERIPH_OUT-1:0] periph_oe_i,
  output logic [NPERIPH_IN-1:0] periph_in_o,
  output logic change_o
);
  import ppr_pkg::*;

  logic [5:0] latch_reg, latch_next, dir_reg, dir_next, od_reg, od_next;
  logic [5:0] slew_reg, slew_next, lvl_reg, lvl_next, ana_reg, ana_next;
  logic [5:0] pu_reg, pu_next, chg_en_reg, chg_en_next, chg_flag_reg, chg_flag_next;
  logic [SEL_W-1:0] osel_reg [NPINS], osel_next [NPINS];
  logic [SEL_W-1:0] isel_reg [NPERIPH_IN], isel_next [NPERIPH_IN];
  logic [5:0] s1_sch_reg, s2_sch_reg, s1_ttl_reg, s2_ttl_reg, prev_reg;
  logic [5:0] in_val, digital_in, chg_edge;
  logic [31:0] dat_next;
  logic ack_next, err_next, req, hit;
  logic [5:0] wdat;
  logic [5:0] drv_out;
  logic [5:0] drv_en;
  logic [5:0] drv_pu;

  // Two-stage synchronisers for both threshold paths
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_sch_reg <= 6'h00;
      s2_sch_reg <= 6'h00;
      s1_ttl_reg <= 6'h00;
      s2_ttl_reg <= 6'h00;
    end else begin
      s1_sch_reg <= pad_i.schmitt; // R12
      s2_sch_reg <= s1_sch_reg; // R12
      s1_ttl_reg <= pad_i.ttl; // R12
      s2_ttl_reg <= s1_ttl_reg; // R12
    end
  end

  // Threshold choice, analog mask and edge detection
  always_comb begin
    in_val = (lvl_reg & s2_ttl_reg) | (~lvl_reg & s2_sch_reg); // R3 R4
    digital_in = in_val & ~ana_reg; // R10
    chg_edge = (digital_in ^ prev_reg) & chg_en_reg; // R4
  end

  // Pad drive, one slice per pin
  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    localparam int IW = $clog2(NPERIPH_OUT);
    logic routed;
    logic [IW-1:0] src;
    // Codes above the peripheral count fall back to latch data
    assign routed = (osel_reg[p] != OUT_SEL_LATCH) && (osel_reg[p] <= SEL_W'(NPERIPH_OUT)); // R7
    assign src = IW'(osel_reg[p] - 3'h1);
    assign drv_out[p] = routed ? periph_out_i[src] : latch_reg[p]; // R6 R7
    // A routed pin drives only when its peripheral enables it
    assign drv_en[p] = (routed ? periph_oe_i[src] : 1'b1) & ~dir_reg[p];
    assign drv_pu[p] = pu_reg[p] & dir_reg[p]; // R11
  end

  // Open-drain pins release the line instead of driving high
  always_comb begin
    pad_o.out = drv_out;
    pad_o.oe = drv_en & (~od_reg | ~drv_out); // R1
    pad_o.slew_limit = slew_reg; // R2
    pad_o.pull_up = drv_pu;
  end

  // Peripheral inputs; selections past the last pin read 0
  for (genvar k = 0; k < NPERIPH_IN; k++) begin : g_route_in
    assign periph_in_o[k] = (isel_reg[k] < SEL_W'(NPINS)) ? digital_in[isel_reg[k]] : 1'b0; // R8
  end

  // Wishbone register file
  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wdat = wb_sel_i[0] ? wb_dat_i[5:0] : 6'h00;
    latch_next = latch_reg;
    dir_next = dir_reg;
    od_next = od_reg;
    slew_next = slew_reg;
    lvl_next = lvl_reg;
    ana_next = ana_reg;
    pu_next = pu_reg;
    chg_en_next = chg_en_reg;
    chg_flag_next = chg_flag_reg | chg_edge;
    osel_next = osel_reg;
    isel_next = isel_reg;
    // Read mux, registered into the answer cycle
    dat_next = 32'h0;
    hit = 1'b1;
    unique case (wb_adr_i)
      OFS_LATCH: dat_next[5:0] = latch_reg;
      OFS_DIR: dat_next[5:0] = dir_reg;
      OFS_OPEN_DRAIN: dat_next[5:0] = od_reg;
      OFS_SLEW: dat_next[5:0] = slew_reg;
      OFS_LEVEL: dat_next[5:0] = lvl_reg;
      OFS_ANALOG: dat_next[5:0] = ana_reg;
      OFS_PULL_UP: dat_next[5:0] = pu_reg;
      OFS_PINS: dat_next[5:0] = digital_in; // R4 R10
      OFS_CHANGE_EN: dat_next[5:0] = chg_en_reg;
      OFS_CHANGE_FLAG: dat_next[5:0] = chg_flag_reg;
      default: begin
        hit = 1'b0;
        for (int p = 0; p < NPINS; p++) begin
          if (wb_adr_i == OFS_OUT_SEL_BASE + 8'(4 * p)) begin
            hit = 1'b1;
            dat_next[SEL_W-1:0] = osel_reg[p];
          end
        end
        for (int k = 0; k < NPERIPH_IN; k++) begin
          if (wb_adr_i == OFS_IN_SEL_BASE + 8'(4 * k)) begin
            hit = 1'b1;
            dat_next[SEL_W-1:0] = isel_reg[k];
          end
        end
      end
    endcase
    // Writes need byte lane 0; other lanes hold no bits
    // Flag clear by writing ones; a same-cycle edge still sets
    if (req && wb_we_i && hit && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        OFS_LATCH: latch_next = wdat;
        OFS_DIR: dir_next = wdat;
        OFS_OPEN_DRAIN: od_next = wdat; // R1
        OFS_SLEW: slew_next = wdat; // R2
        OFS_LEVEL: lvl_next = wdat; // R3
        OFS_ANALOG: ana_next = wdat; // R10
        OFS_PULL_UP: pu_next = wdat;
        OFS_CHANGE_EN: chg_en_next = wdat;
        OFS_CHANGE_FLAG: chg_flag_next = (chg_flag_reg & ~wdat) | chg_edge;
        default: begin
          for (int p = 0; p < NPINS; p++) begin
            if (wb_adr_i == OFS_OUT_SEL_BASE + 8'(4 * p)) begin
              osel_next[p] = wb_dat_i[SEL_W-1:0]; // R7
            end
          end
          for (int k = 0; k < NPERIPH_IN; k++) begin
            if (wb_adr_i == OFS_IN_SEL_BASE + 8'(4 * k)) begin
              isel_next[k] = wb_dat_i[SEL_W-1:0]; // R8
            end
          end
        end
      endcase
    end
    // Answer one cycle after the request is taken
    ack_next = req & hit;
    err_next = req & ~hit;
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_reg <= RST_LATCH;
      dir_reg <= RST_DIR;
      od_reg <= RST_OPEN_DRAIN;
      slew_reg <= RST_SLEW;
      lvl_reg <= RST_LEVEL;
      ana_reg <= RST_ANALOG;
      pu_reg <= RST_PULL_UP;
      chg_en_reg <= 6'h00;
      chg_flag_reg <= 6'h00;
      prev_reg <= 6'h00;
      for (int p = 0; p < NPINS; p++) begin
        osel_reg[p] <= OUT_SEL_LATCH; // R6
      end
      for (int k = 0; k < NPERIPH_IN; k++) begin
        isel_reg[k] <= RST_IN_SEL[k]; // R8
      end
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      dir_reg <= dir_next;
      od_reg <= od_next;
      slew_reg <= slew_next;
      lvl_reg <= lvl_next;
      ana_reg <= ana_next;
      pu_reg <= pu_next;
      chg_en_reg <= chg_en_next;
      chg_flag_reg <= chg_flag_next;
      prev_reg <= digital_in;
      osel_reg <= osel_next;
      isel_reg <= isel_next;
      wb_dat_o <= dat_next;
      wb_ack_o <= ack_next;
      wb_err_o <= err_next;
    end
  end

  // Any pending change flag
  assign change_o = |chg_flag_reg;
endmodule : ppr_port_pad_routing
`default_nettype wire

// ---- hdl/ppr_pkg.sv ----
`default_nettype none
package ppr_pkg;
  localparam int NPINS = 6;
  localparam int NPERIPH_OUT = 4;
  localparam int NPERIPH_IN = 4;
  localparam int SEL_W = 3;
  // Register word offsets (byte addresses)
  localparam logic [7:0] OFS_LATCH = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_OPEN_DRAIN = 8'h08;
  localparam logic [7:0] OFS_SLEW = 8'h0c;
  localparam logic [7:0] OFS_LEVEL = 8'h10;
  localparam logic [7:0] OFS_ANALOG = 8'h14;
  localparam logic [7:0] OFS_PULL_UP = 8'h18;
  localparam logic [7:0] OFS_PINS = 8'h1c;
  localparam logic [7:0] OFS_CHANGE_EN = 8'h20;
  localparam logic [7:0] OFS_CHANGE_FLAG = 8'h24;
  localparam logic [7:0] OFS_OUT_SEL_BASE = 8'h40;
  localparam logic [7:0] OFS_IN_SEL_BASE = 8'h60;
  // Reset values
  localparam logic [5:0] RST_LATCH = 6'h00;
  localparam logic [5:0] RST_DIR = 6'h3f;
  localparam logic [5:0] RST_OPEN_DRAIN = 6'h00;
  localparam logic [5:0] RST_SLEW = 6'h3f;
  localparam logic [5:0] RST_LEVEL = 6'h00;
  localparam logic [5:0] RST_ANALOG = 6'h3f;
  localparam logic [5:0] RST_PULL_UP = 6'h3f;
  localparam logic [2:0] OUT_SEL_LATCH = 3'h0;
  localparam logic [2:0] RST_IN_SEL [NPERIPH_IN] = '{3'h2, 3'h5, 3'h4, 3'h3};

  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] slew_limit;
    logic [5:0] pull_up;
  } ppr_pad_ctl_type;

  typedef struct packed {
    logic [5:0] schmitt;
    logic [5:0] ttl;
  } ppr_pad_in_type;
endpackage : ppr_pkg
`default_nettype wire

// ---- tb/ppr_pad_model.sv ----
`default_nettype none
module ppr_pad_model
  import ppr_pkg::*;
(
  input wire ppr_pkg::ppr_pad_ctl_type pad_o,
  input wire logic [5:0] ext_i,
  input wire logic [5:0] ext_ttl_i,
  output ppr_pkg::ppr_pad_in_type pad_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Driven pins show the drive; others the outside level per receiver
  assign pad_i.schmitt = (pad_o.oe & pad_o.out) | (~pad_o.oe & ext_i);
  assign pad_i.ttl = (pad_o.oe & pad_o.out) | (~pad_o.oe & ext_ttl_i);
endmodule : ppr_pad_model
`default_nettype wire

// ---- tb/ppr_port_pad_routing_checker.sv ----
`default_nettype none
module ppr_port_pad_routing_checker
  import ppr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire ppr_pkg::ppr_pad_in_type pad_i,
  input wire ppr_pkg::ppr_pad_ctl_type pad_o,
  input wire logic [NPERIPH_OUT-1:0] periph_out_i,
  input wire logic [NPERIPH_OUT-1:0] periph_oe_i,
  input wire logic [NPERIPH_IN-1:0] periph_in_o,
  input wire logic change_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
  sequence s_quiet; (!wb_ack_o && $stable(pad_i))[*3]; endsequence
  property p_answer; s_req |=> wb_ack_o || wb_err_o; endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  property p_pulse; wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o; endproperty
  a_pulse: assert property (p_pulse) else $error("long answer");
  property p_excl; !(wb_ack_o && wb_err_o); endproperty
  a_excl: assert property (p_excl) else $error("ack with err");
  property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_pull; (pad_o.pull_up & pad_o.oe) == 6'h00; endproperty
  a_pull: assert property (p_pull) else $error("pull-up on output");
  property p_sync; s_quiet |-> $stable(periph_in_o); endproperty
  a_sync: assert property (p_sync) else $error("input moved");
  property p_pads; !wb_ack_o && $stable(periph_out_i) && $stable(periph_oe_i) |-> $stable(pad_o); endproperty
  a_pads: assert property (p_pads) else $error("pad moved");
  property p_change; (!wb_ack_o && $stable(pad_i))[*5] |-> !$rose(change_o); endproperty
  a_change: assert property (p_change) else $error("stray change");
endmodule : ppr_port_pad_routing_checker
bind ppr_port_pad_routing ppr_port_pad_routing_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pad_i(pad_i),
  .pad_o(pad_o), .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i), .periph_in_o(periph_in_o),
  .change_o(change_o));
`default_nettype wire

// ---- tb/ppr_port_pad_routing_tb.sv ----
`default_nettype none
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin err_total++; \
  $display("[ERR] %0t %h %h", $time, g, x); end end
module ppr_port_pad_routing_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ppr_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, chg, e;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, q;
  logic [3:0] pout = 4'h0, poe = 4'h0, pin, sel = 4'hf;
  logic [5:0] ext = 6'h00, extt = 6'h00;
  ppr_pad_ctl_type pad_o;
  ppr_pad_in_type pad_i;
  int err_total = 0, n_compared = 0, cycles = 0;
  ppr_port_pad_routing dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err),
    .pad_i(pad_i), .pad_o(pad_o), .periph_out_i(pout), .periph_oe_i(poe), .periph_in_o(pin), .change_o(chg));
  ppr_pad_model pads (.pad_o(pad_o), .ext_i(ext), .ext_ttl_i(extt), .pad_i(pad_i));
  initial forever #20 clk_i = ~clk_i;
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    q = rd;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask : rc
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    if (++cycles == 3000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc(OFS_SLEW, 32'h3f);
    rc(OFS_IN_SEL_BASE, 32'h2);
    `CHK({pad_o.oe, pad_o.pull_up}, 12'h03f)
    bus(1'b0, 8'hf0, 32'h0);
    `CHK(e, 1'b1)
    ext <= 6'h15;
    extt <= 6'h2b;
    repeat (4) @(posedge clk_i);
    rc(OFS_PINS, 32'h0);
    bus(1'b1, OFS_ANALOG, 32'h0);
    repeat (3) @(posedge clk_i);
    rc(OFS_PINS, 32'h15);
    bus(1'b1, OFS_LEVEL, 32'h3f);
    repeat (3) @(posedge clk_i);
    rc(OFS_PINS, 32'h2b);
    bus(1'b1, OFS_CHANGE_FLAG, 32'h3f);
    bus(1'b1, OFS_CHANGE_EN, 32'h3f);
    ext <= 6'h0;
    repeat (4) @(posedge clk_i);
    `CHK(chg, 1'b0)
    extt <= 6'h2a;
    repeat (4) @(posedge clk_i);
    `CHK({chg, pin}, 5'h1a)
    bus(1'b1, OFS_CHANGE_FLAG, 32'h3f);
    bus(1'b1, OFS_IN_SEL_BASE, 32'h3);
    `CHK({chg, pin[0]}, 2'b01)
    bus(1'b1, OFS_LATCH, 32'h2a);
    bus(1'b1, OFS_DIR, 32'h0);
    `CHK({pad_o.oe, pad_o.out, pad_o.pull_up}, 18'h3f_a80)
    bus(1'b1, OFS_OPEN_DRAIN, 32'h3f);
    `CHK({pad_o.oe, pad_o.out & pad_o.oe}, 12'h540)
    bus(1'b1, OFS_SLEW, 32'h5);
    `CHK(pad_o.slew_limit, 6'h05)
    bus(1'b1, OFS_OPEN_DRAIN, 32'h0);
    bus(1'b1, OFS_OUT_SEL_BASE + 8'h4, 32'h1);
    bus(1'b1, OFS_IN_SEL_BASE, 32'h1);
    pout <= 4'h1;
    poe <= 4'h1;
    repeat (4) @(posedge clk_i);
    `CHK({pad_o.oe[1], pad_o.out[1], pin[0]}, 3'b111)
    pout <= 4'h0;
    repeat (4) @(posedge clk_i);
    `CHK({pad_o.out[1], pin[0]}, 2'b00)
    bus(1'b1, OFS_ANALOG, 32'h3f);
    `CHK({pad_o.oe[1], pad_o.out[1], pin[0]}, 3'b100)
    sel <= 4'he;
    bus(1'b1, OFS_LATCH, 32'h15);
    sel <= 4'hf;
    rc(OFS_LATCH, 32'h2a);
    finish_test();
  end
endmodule : ppr_port_pad_routing_tb
`default_nettype wire
